// [core/ot_brake_pkg.sv]
package ot_brake_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  A_BASIC     = 8'h00;
  localparam logic [7:0]  A_STOP      = 8'h04;
  localparam logic [7:0]  A_PLUG      = 8'h08;
  localparam logic [7:0]  A_OUTA      = 8'h0c;
  localparam logic [7:0]  A_SON_DLY   = 8'h10;
  localparam logic [7:0]  A_BASIC_DLY = 8'h14;
  localparam logic [7:0]  A_BRK_SPD   = 8'h18;
  localparam logic [7:0]  A_BRK_WAIT  = 8'h1c;
  localparam logic [7:0]  A_STATUS    = 8'h20;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          FWD_DIS_BIT = 4;
  localparam int          REV_DIS_BIT = 8;
  localparam int          DIGIT_W     = 4;
  localparam int          N_TERM      = 3;
  localparam int          N_FUNC      = 10;
  localparam logic [15:0] BASIC_RST   = 16'h0000;
  localparam logic [15:0] STOP_RST    = 16'h0000;
  localparam logic [15:0] PLUG_RST    = 16'h012c;
  localparam logic [15:0] OUTA_RST    = 16'h0210;
  localparam logic [15:0] SON_RST     = 16'h0000;
  localparam logic [15:0] BDLY_RST    = 16'h0000;
  localparam logic [15:0] BSPD_RST    = 16'h0064;
  localparam logic [15:0] BWAIT_RST   = 16'h0032;
  // ****************************************
  // function and stop codes
  // ****************************************
  localparam logic [3:0]  FN_BRAKE    = 4'h4;
  localparam logic [3:0]  FN_OT       = 4'h6;
  localparam logic [3:0]  FN_EXCITED  = 4'h7;
  localparam logic [3:0]  STOP_DB     = 4'h0;
  localparam logic [3:0]  STOP_COAST  = 4'h1;
  localparam logic [3:0]  STOP_PLUG_LO = 4'h2;
  localparam logic [3:0]  STOP_CLAMP_LO = 4'h4;
  localparam logic [3:0]  STOP_MAX    = 4'h5;
  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_NS      = 20;
  localparam int          MS_NS       = 1000000;
  localparam int          CYC_PER_MS  = MS_NS / CLK_NS;
  localparam int          UNIT_10MS   = 10;

  typedef enum logic [2:0] {
    SRV_OFF, SRV_ON_WAIT, SRV_RUN, SRV_OFF_WAIT, SRV_PWR_HOLD
  } srv_t;
  typedef enum logic [1:0] {
    OT_NONE, OT_STOP, OT_COAST, OT_CLAMP
  } ot_t;
endpackage : ot_brake_pkg

// [core/ot_brake_ctrl.sv]
`timescale 1ns/1ps
module ot_brake_ctrl
  import ot_brake_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
)(
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               forward_limit_in,
  input  wire logic               reverse_limit_in,
  input  wire logic               error_clear_in,
  input  wire logic               servo_on_in,
  input  wire logic [15:0]        motor_speed_in,
  input  wire logic [15:0]        rated_torque_max_in,
  input  wire logic [N_FUNC-1:0]  func_in,
  output logic      [N_TERM-1:0]  term_out,
  output logic                    drive_enable_out,
  output logic                    dynamic_brake_out,
  output logic                    plug_brake_out,
  output logic      [15:0]        torque_limit_out,
  output logic                    zero_clamp_out,
  output logic                    overtravel_out,
  output logic                    fwd_allowed_out,
  output logic                    rev_allowed_out,
  output logic                    error_discard_out
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0]        basic;
    logic [15:0]        stop;
    logic [15:0]        plug;
    logic [15:0]        outa;
    logic [15:0]        son_dly;
    logic [15:0]        bdly;
    logic [15:0]        bspd;
    logic [15:0]        bwait;
    logic               cfg_done;
    logic               fwd_dis;
    logic               rev_dis;
    logic [3:0]         stop_code;
    logic [2:0]         fsync;
    logic [2:0]         rsync;
    logic [2:0]         csync;
    logic               fwd_lvl;
    logic               rev_lvl;
    logic               clr_lvl;
    srv_t               srv;
    ot_t                ot;
    logic [31:0]        div;
    logic [15:0]        tmr;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [N_TERM-1:0]  term;
    logic               brake;
    logic               drive;
    logic               db;
    logic               plug_on;
    logic [15:0]        torq;
    logic               clamp;
    logic               ot_out;
    logic               fwd_ok;
    logic               rev_ok;
    logic               discard;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic pick_func(
    input logic [3:0]        code,
    input logic [N_FUNC-1:0] fv
  );
    logic r;
    r = 1'b0;
    if (code < 4'(N_FUNC))
    begin
      r = fv[code];
    end
    return r;
  endfunction : pick_func

  function automatic logic [15:0] min16(
    input logic [15:0] a,
    input logic [15:0] b
  );
    return (a < b) ? a : b;
  endfunction : min16

  logic              tick;
  logic              moving;
  logic              ot_any;
  logic              srv_db;
  logic [3:0]        code;
  logic [15:0]       son_ms;
  logic [15:0]       bdly_ms;
  logic [15:0]       bwait_ms;
  logic [N_FUNC-1:0] fvec;
  logic              wr;
  logic              rd_ok;
  logic [31:0]       rd;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    // one-millisecond enable from the divider
    tick = (st_r.div == 32'(CYC_MS - 1));
    st_nxt.div = tick ? 32'h0000_0000 : st_r.div + 32'h0000_0001;
    if (tick && st_r.tmr != 16'hffff)
    begin
      st_nxt.tmr = st_r.tmr + 16'h0001;
    end

    // three stages; a change counts once stages two and three agree
    st_nxt.fsync = {st_r.fsync[1:0], forward_limit_in};
    st_nxt.rsync = {st_r.rsync[1:0], reverse_limit_in};
    st_nxt.csync = {st_r.csync[1:0], error_clear_in};
    if (st_r.fsync[1] == st_r.fsync[2])
    begin
      st_nxt.fwd_lvl = st_r.fsync[2];
    end
    if (st_r.rsync[1] == st_r.rsync[2])
    begin
      st_nxt.rev_lvl = st_r.rsync[2];
    end
    if (st_r.csync[1] == st_r.csync[2])
    begin
      st_nxt.clr_lvl = st_r.csync[2];
    end

    // limit-disable bits and stop code are caught at the first servo on after reset, so the host
    // loads them first; later writes wait for the next reset
    if (!st_r.cfg_done && servo_on_in)
    begin
      st_nxt.cfg_done  = 1'b1;
      st_nxt.fwd_dis   = st_r.basic[FWD_DIS_BIT];
      st_nxt.rev_dis   = st_r.basic[REV_DIS_BIT];
      st_nxt.stop_code = st_r.stop[DIGIT_W-1:0];
    end
    // out-of-range codes fall back to dynamic brake, the safe stop
    code = (st_r.stop_code > STOP_MAX) ? STOP_DB : st_r.stop_code;
    // servo off brakes dynamically on even codes
    srv_db = ~code[0];

    // no mode input: limits act alike in all control modes
    st_nxt.fwd_ok = st_r.fwd_dis | ~st_r.fwd_lvl;
    st_nxt.rev_ok = st_r.rev_dis | ~st_r.rev_lvl;
    ot_any = ~st_r.fwd_ok | ~st_r.rev_ok;
    // flag moves on the same edge as the allowed outputs
    st_nxt.ot_out = ~st_nxt.fwd_ok | ~st_nxt.rev_ok;
    moving = (motor_speed_in >= st_r.bspd);

    son_ms   = st_r.son_dly[15] ? 16'h0000 : st_r.son_dly;
    bdly_ms  = 16'(st_r.bdly * 16'(UNIT_10MS));
    bwait_ms = 16'(st_r.bwait * 16'(UNIT_10MS));

    // ****************************************
    // servo on/off and holding brake
    // ****************************************
    case (st_r.srv)
      SRV_OFF:
      begin
        st_nxt.brake = 1'b1;
        st_nxt.drive = 1'b0;
        if (servo_on_in && st_r.cfg_done)
        begin
          st_nxt.drive = 1'b1;
          st_nxt.tmr   = 16'h0000;
          if (son_ms != 16'h0000)
          begin
            st_nxt.srv = SRV_ON_WAIT;
          end
          else
          begin
            st_nxt.brake = 1'b0;
            st_nxt.srv   = SRV_RUN;
          end
        end
      end
      SRV_ON_WAIT:
      begin
        if (!servo_on_in)
        begin
          st_nxt.drive = 1'b0;
          st_nxt.srv   = SRV_OFF;
        end
        else if (st_r.tmr >= son_ms)
        begin
          st_nxt.brake = 1'b0;
          st_nxt.srv   = SRV_RUN;
        end
      end
      SRV_RUN:
      begin
        if (!servo_on_in)
        begin
          st_nxt.tmr = 16'h0000;
          if (moving)
          begin
            // power goes, brake waits for speed or time
            st_nxt.drive = 1'b0;
            st_nxt.srv   = SRV_OFF_WAIT;
          end
          else if (bdly_ms != 16'h0000)
          begin
            st_nxt.brake = 1'b1;
            st_nxt.srv   = SRV_PWR_HOLD;
          end
          else
          begin
            // brake and power change on the same edge
            st_nxt.brake = 1'b1;
            st_nxt.drive = 1'b0;
            st_nxt.srv   = SRV_OFF;
          end
        end
      end
      SRV_OFF_WAIT:
      begin
        if (!moving || st_r.tmr >= bwait_ms)
        begin
          st_nxt.brake = 1'b1;
          st_nxt.srv   = SRV_OFF;
        end
      end
      SRV_PWR_HOLD:
      begin
        // motor stays powered until the brake has gripped
        if (st_r.tmr >= bdly_ms)
        begin
          st_nxt.drive = 1'b0;
          st_nxt.srv   = SRV_OFF;
        end
      end
      default:
      begin
        st_nxt.srv = SRV_OFF;
      end
    endcase

    // ****************************************
    // overtravel stop
    // ****************************************
    case (st_r.ot)
      OT_NONE:
      begin
        if (ot_any && st_r.srv == SRV_RUN)
        begin
          st_nxt.ot = OT_STOP;
        end
      end
      OT_STOP:
      begin
        if (!ot_any)
        begin
          st_nxt.ot = OT_NONE;
        end
        else if (!moving)
        begin
          st_nxt.ot = (code >= STOP_CLAMP_LO) ? OT_CLAMP : OT_COAST;
        end
      end
      OT_COAST, OT_CLAMP:
      begin
        if (!ot_any)
        begin
          st_nxt.ot = OT_NONE;
        end
      end
      default:
      begin
        st_nxt.ot = OT_NONE;
      end
    endcase

    // drive is cut while coasting or braking dynamically
    if (st_nxt.ot == OT_COAST ||
        (st_nxt.ot == OT_STOP && code < STOP_PLUG_LO))
    begin
      st_nxt.drive = 1'b0;
    end
    st_nxt.db = moving &&
      ((st_nxt.ot == OT_STOP && code == STOP_DB) ||
       (!st_nxt.drive && st_r.srv != SRV_RUN && srv_db &&
        st_nxt.ot == OT_NONE));
    st_nxt.plug_on = (st_nxt.ot == OT_STOP) && (code >= STOP_PLUG_LO);
    st_nxt.clamp   = (st_nxt.ot == OT_CLAMP);
    // rating caps the setting; the setting is read live
    st_nxt.torq = min16(st_r.plug, rated_torque_max_in);

    // clear input discards pending position error
    st_nxt.discard = st_r.clr_lvl;

    // ****************************************
    // output terminal routing
    // ****************************************
    fvec = func_in;
    fvec[FN_BRAKE]   = st_r.brake;
    fvec[FN_OT]      = st_r.ot_out;
    fvec[FN_EXCITED] = st_r.drive;
    for (int t = 0; t < N_TERM; t++)
    begin
      // only a digit holding the brake code carries it
      st_nxt.term[t] =
        pick_func(st_r.outa[t*DIGIT_W +: DIGIT_W], fvec);
    end

    // ****************************************
    // apb slave, zero wait states
    // ****************************************
    rd_ok = 1'b1;
    rd    = 32'h0000_0000;
    case (paddr)
      A_BASIC:     rd[15:0] = st_r.basic;
      A_STOP:      rd[15:0] = st_r.stop;
      A_PLUG:      rd[15:0] = st_r.plug;
      A_OUTA:      rd[15:0] = st_r.outa;
      A_SON_DLY:   rd[15:0] = st_r.son_dly;
      A_BASIC_DLY: rd[15:0] = st_r.bdly;
      A_BRK_SPD:   rd[15:0] = st_r.bspd;
      A_BRK_WAIT:  rd[15:0] = st_r.bwait;
      A_STATUS:
      begin
        rd[15:0] = {st_r.torq[8:0], st_r.ot, st_r.srv, st_r.brake,
                    st_r.fwd_lvl};
        rd[16]   = st_r.rev_lvl;
        rd[17]   = st_r.fwd_ok;
        rd[18]   = st_r.rev_ok;
        rd[22:19] = st_r.stop_code;
      end
      default:     rd_ok = 1'b0;
    endcase
    wr = psel && penable && pwrite && st_r.pready && rd_ok;
    st_nxt.pready  = psel && !penable;
    st_nxt.pslverr = psel && !penable && !rd_ok;
    if (psel && !penable && !pwrite)
    begin
      st_nxt.prdata = rd;
    end
    if (wr)
    begin
      case (paddr)
        A_BASIC:     st_nxt.basic   = pwdata[15:0];
        A_STOP:      st_nxt.stop    = pwdata[15:0];
        A_PLUG:      st_nxt.plug    = pwdata[15:0];
        A_OUTA:      st_nxt.outa    = pwdata[15:0];
        A_SON_DLY:   st_nxt.son_dly = pwdata[15:0];
        A_BASIC_DLY: st_nxt.bdly    = pwdata[15:0];
        A_BRK_SPD:   st_nxt.bspd    = pwdata[15:0];
        A_BRK_WAIT:  st_nxt.bwait   = pwdata[15:0];
        default:     st_nxt.basic   = st_r.basic;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r         <= '0;
      st_r.basic   <= BASIC_RST;
      st_r.stop    <= STOP_RST;
      st_r.plug    <= PLUG_RST;
      st_r.outa    <= OUTA_RST;
      st_r.son_dly <= SON_RST;
      st_r.bdly    <= BDLY_RST;
      st_r.bspd    <= BSPD_RST;
      st_r.bwait   <= BWAIT_RST;
      st_r.brake   <= 1'b1;
      st_r.srv     <= SRV_OFF;
      st_r.ot      <= OT_NONE;
      st_r.fwd_ok  <= 1'b1;
      st_r.rev_ok  <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata            = st_r.prdata;
  assign pready            = st_r.pready;
  assign pslverr           = st_r.pslverr;
  assign term_out          = st_r.term;
  assign drive_enable_out  = st_r.drive;
  assign dynamic_brake_out = st_r.db;
  assign plug_brake_out    = st_r.plug_on;
  assign torque_limit_out  = st_r.torq;
  assign zero_clamp_out    = st_r.clamp;
  assign overtravel_out    = st_r.ot_out;
  assign fwd_allowed_out   = st_r.fwd_ok;
  assign rev_allowed_out   = st_r.rev_ok;
  assign error_discard_out = st_r.discard;
endmodule : ot_brake_ctrl

// [verif/ot_brake_sva.sv]
`timescale 1ns/1ps
module ot_brake_sva
  import ot_brake_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              forward_limit_in,
  input wire logic              error_clear_in,
  input wire logic [15:0]       rated_torque_max_in,
  input wire logic [15:0]       torque_limit_out,
  input wire logic              drive_enable_out,
  input wire logic              dynamic_brake_out,
  input wire logic              plug_brake_out,
  input wire logic              zero_clamp_out,
  input wire logic              overtravel_out,
  input wire logic              fwd_allowed_out,
  input wire logic              rev_allowed_out,
  input wire logic              error_discard_out
);
  // ****************************************
  // port checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  bad_addr_a: assert property (psel && !penable && paddr > A_STATUS
    |=> pready && pslverr) else $error("unmapped access not refused");
  err_cause_a: assert property (pslverr |-> pready && paddr > A_STATUS)
    else $error("error on a mapped address");
  fwd_release_a: assert property (
    !forward_limit_in [*5] |=> fwd_allowed_out)
    else $error("forward stays blocked");
  ot_flag_a: assert property (
    overtravel_out |-> !(fwd_allowed_out && rev_allowed_out))
    else $error("overtravel with both directions free");
  db_unpowered_a: assert property (
    dynamic_brake_out |-> !drive_enable_out && !plug_brake_out)
    else $error("dynamic brake while powered");
  clamp_alone_a: assert property (
    zero_clamp_out |-> !dynamic_brake_out && !plug_brake_out)
    else $error("clamp mixed with braking");
  plug_on_ot_a: assert property (
    plug_brake_out |-> overtravel_out || $past(overtravel_out))
    else $error("plug braking without overtravel");
  torque_cap_a: assert property (
    $stable(rated_torque_max_in) [*3] |->
    torque_limit_out <= rated_torque_max_in)
    else $error("torque above motor rating");
  clear_follow_a: assert property (
    $stable(error_clear_in) [*5] |=> error_discard_out == $past(error_clear_in))
    else $error("discard does not follow clear");
  cover property (zero_clamp_out);
  cover property (plug_brake_out);
  cover property (dynamic_brake_out);
  cover property (pslverr);
endmodule : ot_brake_sva

// [verif/limit_relay_model.sv]
`timescale 1ns/1ps
module limit_relay_model (
  input  wire logic       mclk,
  input  wire logic [1:0] hit,
  input  wire logic       brake_line,
  output logic            forward_limit_in,
  output logic            reverse_limit_in,
  output logic            brake_held
);
  // ****************************************
  // switches chatter on every move
  // ****************************************
  logic [1:0] lvl_r = 2'b00;
  logic [1:0] bounce_r [2] = '{2'd0, 2'd0};
  // a real contact bounces, so the drive must not act on single samples
  always @(posedge mclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (bounce_r[i] != 2'd0)
      begin
        bounce_r[i] <= bounce_r[i] - 2'd1;
        lvl_r[i]    <= (bounce_r[i] == 2'd1) ? hit[i] : ~lvl_r[i];
      end
      else if (hit[i] != lvl_r[i])
        bounce_r[i] <= 2'd3;
    end
  end
  assign forward_limit_in = lvl_r[0];
  assign reverse_limit_in = lvl_r[1];
  assign brake_held       = brake_line;
endmodule : limit_relay_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb
  import ot_brake_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  localparam int CYC   = 5;
  localparam int WATCH = 20000;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdata;
  logic              forward_limit_in, reverse_limit_in, brake_held;
  logic              error_clear_in, servo_on_in, error_discard_out;
  logic [15:0]       motor_speed_in, rated_torque_max_in, torque_limit_out;
  logic [9:0]        func_in;
  logic [2:0]        term_out;
  logic [1:0]        hit;
  logic              drive_enable_out, dynamic_brake_out, plug_brake_out;
  logic              zero_clamp_out, overtravel_out;
  logic              fwd_allowed_out, rev_allowed_out;
  int                errors = 0;
  int                checks = 0;
  logic [15:0]       rst_val [8] = '{BASIC_RST, STOP_RST, PLUG_RST, OUTA_RST,
                                    SON_RST, BDLY_RST, BSPD_RST, BWAIT_RST};

  always #(CLK_NS / 2) mclk = ~mclk;
  ot_brake_ctrl #(.CYC_MS(CYC)) dut (.*);
  limit_relay_model lsw (.mclk(mclk), .hit(hit), .brake_line(term_out[0]),
    .forward_limit_in(forward_limit_in), .reverse_limit_in(reverse_limit_in),
    .brake_held(brake_held));

  // ****************************************
  // tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do
    begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge mclk);
  endtask : apb
  task automatic power_cycle();
    rst <= 1'b1;
    cyc(16);
    rst <= 1'b0;
    cyc(4);
  endtask : power_cycle
  task automatic servo_run(input logic [15:0] spd, input int drop,
                           input int lo, input int hi);
    int n;
    n = 0;
    servo_on_in <= 1'b1;
    motor_speed_in <= spd;
    cyc(4);
    chk("brake released", 32'h0, 32'(brake_held));
    servo_on_in <= 1'b0;
    while (brake_held !== 1'b1 && n < 2000)
    begin
      @(posedge mclk);
      n++;
      if (n == drop) motor_speed_in <= 16'h0000;
    end
    chk("brake timing", 32'h1, 32'(n >= lo && n <= hi));
    chk("drive off", 32'h0, 32'(drive_enable_out));
  endtask : servo_run
  function automatic logic [3:0] ot_exp(input int c, input bit stopped);
    // order: dynamic brake, drive, plug, clamp
    if (stopped) return (c >= 4) ? 4'b0101 : 4'b0000;
    return (c == 0) ? 4'b1000 : (c == 1) ? 4'b0000 : 4'b0110;
  endfunction : ot_exp
  function automatic logic term_exp(input int c, input logic [9:0] fv);
    // servo is off here: brake applied, motor unexcited, no limit tripped
    if (c == 4) return 1'b1;
    if (c == 6 || c == 7) return 1'b0;
    return fv[c];
  endfunction : term_exp
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    logic [31:0] fv;
    logic [15:0] pl;
    logic [15:0] rt;
    void'($urandom(32'h05b8));
    {psel, penable, pwrite, servo_on_in, error_clear_in, hit} = '0;
    {paddr, pwdata, motor_speed_in, func_in} = '0;
    rated_torque_max_in = 16'h012c;
    cyc(16);
    rst <= 1'b0;
    cyc(2);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", {16'h0, rst_val[i]}, rdata);
    end
    for (int i = 2; i < 8; i++)
    begin
      fv = $urandom;
      apb(1'b1, 8'(4 * i), fv);
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("read back", {16'h0, fv[15:0]}, rdata);
      apb(1'b1, 8'(4 * i), {16'h0, rst_val[i]});
    end
    apb(1'b1, 8'h24, $urandom);
    chk("unmapped error", 32'h1, 32'(rerr));
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped data", 32'h0, rdata);
    $display("test registers done");
    fv = $urandom;
    func_in <= fv[9:0];
    cyc(3);
    chk("factory terms", {29'h0, fv[2:0]}, 32'(term_out));
    for (int c = 0; c < 10; c++)
    begin
      fv = $urandom;
      func_in <= fv[9:0];
      apb(1'b1, A_OUTA, {20'h0, 8'h44, 4'(c)});
      cyc(2);
      chk("terminal map", {29'h0, 2'b11, term_exp(c, fv[9:0])},
          32'(term_out));
    end
    $display("test terminals done");
    apb(1'b1, A_OUTA, 32'h0000_0214);
    apb(1'b1, A_BRK_WAIT, 32'h0000_000a);
    servo_run(16'h0000, 0, 1, 3);
    servo_run(16'h01f4, 40, 40, 45);
    servo_run(16'h01f4, 0, 495, 506);
    $display("test brake timing done");
    rt = 16'(50 + $urandom_range(250));
    rated_torque_max_in <= rt;
    for (int c = 0; c < 6; c++)
    begin
      power_cycle();
      apb(1'b1, A_STOP, 32'(c));
      pl = 16'($urandom_range(300));
      apb(1'b1, A_PLUG, {16'h0, pl});
      {servo_on_in, motor_speed_in} <= {1'b1, 16'h03e8};
      cyc(4);
      hit <= (c % 2) ? 2'b10 : 2'b01;
      cyc(12);
      chk("overtravel", 32'h1, 32'(overtravel_out));
      chk("allowed", (c % 2) ? 32'h2 : 32'h1,
          32'({fwd_allowed_out, rev_allowed_out}));
      chk("stopping", 32'(ot_exp(c, 1'b0)), 32'({dynamic_brake_out,
          drive_enable_out, plug_brake_out, zero_clamp_out}));
      if (c >= 2) chk("plug torque", 32'((pl < rt) ? pl : rt),
          32'(torque_limit_out));
      {motor_speed_in, error_clear_in} <= {16'h0000, 1'b1};
      cyc(8);
      chk("stopped", 32'(ot_exp(c, 1'b1)), 32'({dynamic_brake_out,
          drive_enable_out, plug_brake_out, zero_clamp_out}));
      chk("discard", 32'h1, 32'(error_discard_out));
      {hit, servo_on_in, error_clear_in} <= '0;
      cyc(12);
      chk("limit cleared", 32'h0, 32'(overtravel_out));
      $display("test stop code %0d done", c);
    end
    apb(1'b1, A_BASIC, 32'h0000_0110);
    {hit, servo_on_in} <= 3'b111;
    cyc(12);
    chk("old digits", 32'h0, 32'({fwd_allowed_out, rev_allowed_out}));
    {hit, servo_on_in} <= '0;
    cyc(8);
    power_cycle();
    apb(1'b1, A_BASIC, 32'h0000_0110);
    {hit, servo_on_in} <= 3'b111;
    cyc(12);
    chk("limits ignored", 32'h7, 32'({fwd_allowed_out,
        rev_allowed_out, !overtravel_out}));
    $display("test limit enables done");
    finish_test();
  end

  initial
  begin
    #(CLK_NS * WATCH);
    errors++;
    finish_test();
  end
endmodule : tb

bind ot_brake_ctrl ot_brake_sva sva (.*);
